/* File: rsw_pkg.sv */
/*
  Shared constants, types and helpers of the relay switch serial frame
  logic. Assumes 16-bit frames, eight channels and a 3-bit register pointer.
*/
`default_nettype none

package rsw_pkg;

  // Frame layout
  localparam int FRAME_W = 16;
  localparam int CMD_HI  = 15;
  localparam int CMD_LO  = 14;
  localparam int ADDR_HI = 10;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam int DATA_LO = 0;
  localparam int NCH     = 8;

  typedef logic [1:0] rsw_cmd_t;
  typedef logic [2:0] rsw_addr_t;
  typedef logic [7:1][7:0] rsw_regs_t;

  // Command codes
  localparam rsw_cmd_t CMD_DIAG  = 2'h0;
  localparam rsw_cmd_t CMD_READ  = 2'h1;
  localparam rsw_cmd_t CMD_RESET = 2'h2;
  localparam rsw_cmd_t CMD_WRITE = 2'h3;

  // Register pointers
  localparam rsw_addr_t ADDR_NONE = 3'h0;
  localparam rsw_addr_t ADDR_STAT = 3'h6;

  // Register defaults, index 7 down to 1
  localparam rsw_regs_t REG_DEFAULTS =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};

  // Channel diagnosis codes
  localparam logic [1:0] DIAG_SHORT  = 2'h0;
  localparam logic [1:0] DIAG_OPEN   = 2'h1;
  localparam logic [1:0] DIAG_OVER   = 2'h2;
  localparam logic [1:0] DIAG_NORMAL = 2'h3;

  // Header of the read answer frame, bits 15 to 11
  localparam logic [4:0] READ_HDR   = 5'h08;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [2:0] BIT_ZERO   = 3'h0;
  localparam logic [2:0] BIT_STEP   = 3'h1;

  // Synchroniser state, bit 0 is the first flip-flop
  typedef struct packed {
    logic [2:0] cs;
    logic [2:0] sck;
    logic [1:0] si;
  } rsw_sync_t;

  // Frame logic state
  typedef struct packed {
    logic [FRAME_W-1:0] sr;
    logic               so;
    logic               so_oe;
    logic [2:0]         bits;
    logic               got_byte;
    logic               pend;
    rsw_addr_t          pend_addr;
    logic [NCH-1:0]     f_short;
    logic [NCH-1:0]     f_open;
    logic [NCH-1:0]     f_over;
    rsw_regs_t          regs;
  } rsw_core_t;

  // Standard diagnosis word, two bits per channel
  function automatic logic [FRAME_W-1:0] diag_word
  (
    input logic [NCH-1:0] sh,
    input logic [NCH-1:0] op,
    input logic [NCH-1:0] ov
  );
    logic [FRAME_W-1:0] w;
    w = '0;
    for (int n = 0; n < NCH; n++)
    begin
      if (ov[n])
        w[2*n +: 2] = DIAG_OVER;
      else if (sh[n])
        w[2*n +: 2] = DIAG_SHORT;
      else if (op[n])
        w[2*n +: 2] = DIAG_OPEN;
      else
        w[2*n +: 2] = DIAG_NORMAL;
    end
    return w;
  endfunction

  // Pointers that hold a writable register
  function automatic logic writable(input rsw_addr_t a);
    return (a != ADDR_NONE) && (a != ADDR_STAT);
  endfunction

endpackage

`default_nettype wire

/* File: rsw_pin_if.sv */
/*
  Synchronised serial pin view passed from the pin synchroniser to the
  frame logic. Assumes both ends run on mclk.
*/
`timescale 1ns/1ns
`default_nettype none

interface rsw_pin_if;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic sclk_rise;
  logic sclk_fall;
  logic si;

  modport sync
  (
    output cs_fall,
    output cs_rise,
    output cs_low,
    output sclk_rise,
    output sclk_fall,
    output si
  );

  modport core
  (
    input cs_fall,
    input cs_rise,
    input cs_low,
    input sclk_rise,
    input sclk_fall,
    input si
  );
endinterface

`default_nettype wire

/* File: rsw_pin_sync.sv */
/*
  Two-stage synchronisers for chip select, serial clock and serial input, and
  edge finders for chip select and serial clock. Assumes the serial clock is far slower than mclk.
*/
`timescale 1ns/1ns
`default_nettype none

module rsw_pin_sync
  import rsw_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic si,
  rsw_pin_if.sync   pin
);

  rsw_sync_t q;
  rsw_sync_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Shift chains; the first stage feeds only the second
  always_comb
  begin
    d     = q;
    d.cs  = {q.cs[1:0], cs_n};
    d.sck = {q.sck[1:0], sclk};
    d.si  = {q.si[0], si};
  end

  // Chip select idles high after reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      q     <= '0;
      q.cs  <= 3'h7;
    end
    else if (ce)
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge pulses from the second and third stages
  assign pin.cs_fall   = q.cs[2] & ~q.cs[1];
  assign pin.cs_rise   = ~q.cs[2] & q.cs[1];
  assign pin.cs_low    = ~q.cs[1];
  assign pin.sclk_rise = ~q.sck[2] & q.sck[1];
  assign pin.sclk_fall = q.sck[2] & ~q.sck[1];
  assign pin.si        = q.si[1];

endmodule

`default_nettype wire

/* File: rsw_spi_frame.sv */
/*
  Serial frame logic of an eight-channel low-side switch: shift register,
  command decode, control registers, latched diagnosis and read-back.
  Assumes the pins come from another clock domain; the channel event
  inputs and status come from logic on mclk.
*/
// Function
// RQ1 - Power-on reset loads every control register with its default.
// RQ2 - Frame decodes as command bits 15:14, address field, data byte.
// RQ3 - Diagnosis-only shifts out diagnosis and changes no register.
// RQ4 - Read returns the addressed register in the following frame.
// RQ5 - Reset-registers command returns all registers to their defaults.
// RQ6 - Write stores the data byte into the addressed register.
// RQ7 - Bits 10:8 hold the register pointer for read and write.
// RQ8 - Bits 7:0 hold the byte written or read back.
// RQ9 - Channel n diagnosis sits in bits 2n+1 and 2n of the word.
// RQ10 - Pair codes: 00 short, 01 open, 10 overload, 11 normal.
// RQ11 - Master drives bits 13:11 to zero; command codes are chosen here.
// RQ12 - Falling chip select loads diagnosis into the shift register.
// RQ13 - Rising chip select decodes only after a multiple of eight clocks.
// RQ14 - Rising chip select clears the latched diagnosis flags.
// RQ15 - Sample input on falling clock, update output on rising, MSB first.
`timescale 1ns/1ns
`default_nettype none

module rsw_spi_frame
  import rsw_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rst,
  input  wire logic           ce,
  input  wire logic           cs_n,
  input  wire logic           sclk,
  input  wire logic           si,
  output var  logic           so,
  output var  logic           so_oe,
  input  wire logic [NCH-1:0] ch_short,
  input  wire logic [NCH-1:0] ch_open,
  input  wire logic [NCH-1:0] ch_over,
  input  wire logic [7:0]     out_status,
  output var  rsw_regs_t      regs_q
);

  rsw_pin_if pin ();

  rsw_core_t          q;
  rsw_core_t          d;
  logic [7:0]         rd_byte;
  logic               good_end;
  rsw_cmd_t           cmd;
  rsw_addr_t          addr;
  logic [7:0]         data;
  logic [FRAME_W-1:0] load_word;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  rsw_pin_sync u_sync
  (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .cs_n (cs_n),
    .sclk (sclk),
    .si   (si),
    .pin  (pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame fields and read-back byte
  always_comb
  begin
    cmd      = q.sr[CMD_HI:CMD_LO];                        // [RQ2]
    addr     = q.sr[ADDR_HI:ADDR_LO];                      // [RQ7]
    data     = q.sr[DATA_HI:DATA_LO];                      // [RQ8]
    good_end = q.got_byte && (q.bits == BIT_ZERO);         // [RQ13]
    if (q.pend_addr == ADDR_STAT)
      rd_byte = out_status;
    else if (q.pend_addr == ADDR_NONE)
      rd_byte = 8'h00;
    else
      rd_byte = q.regs[q.pend_addr];
    if (q.pend)
      load_word = {READ_HDR, q.pend_addr, rd_byte};        // [RQ4] [RQ8]
    else
      load_word = diag_word(q.f_short, q.f_open, q.f_over); // [RQ9] [RQ10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    // Sticky flags; a new event wins over the clear
    d.f_short = (pin.cs_rise ? '0 : q.f_short) | ch_short; // [RQ14]
    d.f_open  = (pin.cs_rise ? '0 : q.f_open) | ch_open;   // [RQ14]
    d.f_over  = (pin.cs_rise ? '0 : q.f_over) | ch_over;   // [RQ14]
    if (pin.cs_fall)
    begin
      d.sr       = load_word;                              // [RQ12]
      d.so       = load_word[FRAME_W-1];
      d.so_oe    = 1'b1;
      d.bits     = BIT_ZERO;
      d.got_byte = 1'b0;
      d.pend     = 1'b0;
    end
    else if (pin.cs_low)
    begin
      if (pin.sclk_rise)
        d.so = q.sr[FRAME_W-1];                            // [RQ15]
      if (pin.sclk_fall)
      begin
        d.sr   = {q.sr[FRAME_W-2:0], pin.si};              // [RQ15]
        d.bits = q.bits + BIT_STEP;
        if (q.bits == LAST_BIT)
          d.got_byte = 1'b1;
      end
    end
    if (pin.cs_rise)
    begin
      d.so_oe = 1'b0;
      if (good_end)                                        // [RQ13]
      begin
        d.pend      = (cmd == CMD_READ);                   // [RQ4]
        d.pend_addr = addr;                                // [RQ7]
        unique case (cmd)
          CMD_DIAG  : ;                                    // [RQ3]
          CMD_READ  : ;
          CMD_RESET : d.regs = REG_DEFAULTS;               // [RQ5]
          CMD_WRITE :
          begin
            if (writable(addr))
              d.regs[addr] = data;                         // [RQ6] [RQ8]
          end
        endcase
      end
    end
  end

  // State register; reset acts even while frozen
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      q      <= '0;
      q.regs <= REG_DEFAULTS;                              // [RQ1]
    end
    else if (ce)
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign so     = q.so;
  assign so_oe  = q.so_oe;
  assign regs_q = q.regs;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_end_ok;
    ce && pin.cs_rise && good_end;
  endsequence

  sequence s_start;
    ce && pin.cs_fall;
  endsequence

  reset_defaults_a : assert property ( // [RQ1]
    $fell(rst) |-> (q.regs == REG_DEFAULTS) && !q.pend)
    else $error("registers not at defaults after reset");

  write_store_a : assert property ( // [RQ6]
    s_end_ok ##0 (cmd == CMD_WRITE) ##0 writable(addr)
    |=> q.regs[$past(addr)] == $past(data))
    else $error("write data not stored");

  reset_cmd_a : assert property ( // [RQ5]
    s_end_ok ##0 (cmd == CMD_RESET) |=> q.regs == REG_DEFAULTS)
    else $error("reset command did not restore defaults");

  diag_keep_a : assert property ( // [RQ3]
    s_end_ok ##0 (cmd == CMD_DIAG) |=> $stable(q.regs) && !q.pend)
    else $error("diagnosis command changed registers");

  read_pend_a : assert property ( // [RQ4]
    s_end_ok ##0 (cmd == CMD_READ)
    |=> q.pend && (q.pend_addr == $past(addr)))
    else $error("read not held for next frame");

  read_answer_a : assert property ( // [RQ4]
    s_start ##0 q.pend
    |=> (q.sr[FRAME_W-1:ADDR_HI+1] == READ_HDR) && !q.pend && q.so_oe)
    else $error("read answer not loaded");

  diag_load_a : assert property ( // [RQ12]
    s_start ##0 !q.pend
    |=> q.sr == diag_word($past(q.f_short), $past(q.f_open),
                          $past(q.f_over)))
    else $error("diagnosis word not loaded");

  bad_count_a : assert property ( // [RQ13]
    ce && pin.cs_rise && !good_end
    |=> $stable(q.regs) && (q.pend == $past(q.pend)))
    else $error("decode after partial byte");

  flag_clear_a : assert property ( // [RQ14]
    ce && pin.cs_rise |=> (q.f_over == $past(ch_over))
                          && (q.f_short == $past(ch_short)))
    else $error("flags not cleared at frame end");

  so_shift_a : assert property ( // [RQ15]
    ce && pin.cs_low && !pin.cs_fall && pin.sclk_rise
    |=> so == $past(q.sr[FRAME_W-1]))
    else $error("serial output not updated on rising clock");

endmodule

`default_nettype wire

/* File: rsw_spi_master.sv */
/*
  Serial master model that drives frames into the relay switch frame logic.
  Assumes mclk at 50 ns; the serial clock period is 8 mclk (400 ns).
*/
`timescale 1ns/1ns
`default_nettype none

module rsw_spi_master
(
  input  wire logic mclk,
  input  wire logic so,
  input  wire logic so_oe,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic si,
  output var  logic oe_ok
);
  logic act;
  logic bitv;
  logic so_pin;

  // Released output has no pull: show the inverse so a late sample shows up
  assign so_pin = so_oe ? so : ~so;

  // Idle levels: deselected, clock low
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    act = 1'b0;
    bitv = 1'b0;
    oe_ok = 1'b1;
  end

  // Serial input toggles while idle so that ignored bits are never stale
  always @(posedge mclk)
    si <= act ? bitv : ~si;

  ////////////////////////////////////////////////////////////////////////////
  // One frame of n bits, MSB first; so sampled just before each fall
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    rx = '0;
    oe_ok = 1'b1;
    @(posedge mclk);
    cs_n <= 1'b0;
    act <= 1'b1;
    bitv <= tx[n-1];
    repeat (6) @(posedge mclk);
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk <= 1'b1;
      repeat (2) @(posedge mclk);
      bitv <= tx[i];
      repeat (3) @(posedge mclk);
      rx = {rx[30:0], so_pin};
      oe_ok = oe_ok & so_oe;
      sclk <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    cs_n <= 1'b1;
    act <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule

`default_nettype wire

/* File: relay_switch_spi_frame_logic_tb.sv */
/*
  Self-checking bench of the relay switch frame logic.
  Assumes the master model drives the serial pins.
*/
`timescale 1ns/1ns
`default_nettype none

module relay_switch_spi_frame_logic_tb;
  import rsw_pkg::*;

  logic mclk, rst, ce, cs_n, sclk, si, so, so_oe, oe_ok;
  logic [NCH-1:0] ch_short, ch_open, ch_over;
  logic [7:0] out_status;
  rsw_regs_t regs_q;
  logic [7:0] mdl [8];
  logic [31:0] rx;
  int errors = 0;
  int tests_run = 0;

  rsw_spi_frame u_dut (.mclk(mclk), .rst(rst), .ce(ce), .cs_n(cs_n),
    .sclk(sclk), .si(si), .so(so), .so_oe(so_oe), .ch_short(ch_short),
    .ch_open(ch_open), .ch_over(ch_over), .out_status(out_status),
    .regs_q(regs_q));
  rsw_spi_master u_master (.mclk(mclk), .so(so), .so_oe(so_oe),
    .cs_n(cs_n), .sclk(sclk), .si(si), .oe_ok(oe_ok));

  // 20 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // Expected register file; pointer 6 is status and never stored
  function automatic rsw_regs_t exp_regs();
    rsw_regs_t r;
    for (int i = 1; i < 8; i++)
      r[i] = (i == 6) ? 8'h00 : mdl[i];
    return r;
  endfunction

  function automatic logic [7:0] rd_exp(input int p);
    return (p == 6) ? out_status : mdl[p];
  endfunction

  task automatic frame(input rsw_cmd_t c, input rsw_addr_t a,
                       input logic [7:0] d, input int n);
    u_master.xfer({8'h00, 8'hA5, c, 3'h0, a, d}, n, rx);
    check({so_oe, oe_ok}, 2'h1, "output enable framing");
  endtask

  task automatic end_test(input string name);
    $display("Test %s done", name);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    ch_short = '0;
    ch_open = '0;
    ch_over = '0;
    out_status = 8'h5A;
    for (int i = 0; i < 8; i++)
      mdl[i] = (i == 0) ? 8'h00 : REG_DEFAULTS[i];
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check(regs_q, exp_regs(), "defaults after reset");
    end_test("reset");
    // Latched events: overload beats short beats open
    ch_over <= 8'h84;
    ch_short <= 8'h26;
    ch_open <= 8'h0A;
    @(posedge mclk);
    ch_over <= 8'h00;
    ch_short <= 8'h00;
    ch_open <= 8'h00;
    repeat (2) @(posedge mclk);
    frame(CMD_DIAG, 3'h7, 8'hFF, 16);
    check(rx[15:0], 16'hB363, "diagnosis word");
    check(regs_q, exp_regs(), "diag changed regs");
    frame(CMD_DIAG, 3'h0, 8'h00, 16);
    check(rx[15:0], 16'hFFFF, "flags not cleared");
    end_test("diagnosis");
    // Write every pointer, including read-only ones
    for (int p = 0; p < 8; p++)
    begin
      frame(CMD_WRITE, 3'(p), 8'hA0 + 8'(p), 16);
      if (p != 0 && p != 6)
        mdl[p] = 8'hA0 + 8'(p);
    end
    check(regs_q, exp_regs(), "write registers");
    end_test("write");
    // Back-to-back reads, each answer in the next frame
    frame(CMD_READ, 3'h0, 8'h00, 16);
    check(rx[15:0], 16'hFFFF, "read answered early");
    for (int p = 1; p < 9; p++)
    begin
      frame((p < 8) ? CMD_READ : CMD_DIAG, 3'(p), 8'h00, 16);
      check(rx[15:0], {READ_HDR, 3'(p - 1), rd_exp(p - 1)},
            "read answer");
    end
    end_test("read");
    // Bad bit count refused, longer chain frame accepted
    frame(CMD_WRITE, 3'h1, 8'h3C, 12);
    check(regs_q, exp_regs(), "partial frame decoded");
    frame(CMD_WRITE, 3'h1, 8'h3C, 24);
    mdl[1] = 8'h3C;
    check(regs_q, exp_regs(), "chained frame lost");
    end_test("framing");
    frame(CMD_RESET, 3'h0, 8'h00, 16);
    for (int i = 1; i < 8; i++)
      mdl[i] = REG_DEFAULTS[i];
    check(regs_q, exp_regs(), "reset command");
    end_test("reset command");
    // Clock enable low freezes state: an event then is never latched
    ce <= 1'b0;
    ch_over <= 8'h01;
    @(posedge mclk);
    ch_over <= 8'h00;
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    frame(CMD_WRITE, 3'h7, 8'h5C, 16);
    check(rx[15:0], 16'hFFFF, "event latched while frozen");
    mdl[7] = 8'h5C;
    check(regs_q, exp_regs(), "write after freeze");
    end_test("clock enable");
    // Reset in mid-run brings every register back to its default
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int i = 1; i < 8; i++)
      mdl[i] = REG_DEFAULTS[i];
    check(regs_q, exp_regs(), "defaults after second reset");
    frame(CMD_READ, 3'h1, 8'h00, 16);
    check(rx[15:0], 16'hFFFF, "diagnosis after second reset");
    frame(CMD_DIAG, 3'h0, 8'h00, 16);
    check(rx[15:0], {READ_HDR, 3'h1, rd_exp(1)}, "default read");
    end_test("second reset");
    finish_test();
  end
endmodule

`default_nettype wire
